// *** dv/gpe_pins_model.sv ***
// far-side pin model for the port block
`default_nettype none
module gpe_pins_model (
  input wire logic [5:0] drv_i,
  input wire logic [5:0] oe_i,
  input wire logic [5:0] ext_i,
  output wire logic [5:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // outside drivers give way where the port drives, avoiding contention
  assign lvl_o = oe_i & drv_i | ~oe_i & ext_i;
endmodule // gpe_pins_model
`default_nettype wire

// *** dv/gpe_port_chk.sv ***
// concurrent checks on the port block
`default_nettype none
module gpe_port_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [5:0] pin_i,
  input wire [5:0] pin_o,
  input wire [5:0] pin_oe_o,
  input wire [5:0] analog_mode_o
);
  wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [9:0] ix = wb_adr_i[11:2];
  wire wr = tk & wb_we_i & wb_sel_i[0];
  wire [5:0] d6 = wb_dat_i[5:0];
  wire lw = wr & (ix == 10'h005 | ix == 10'h092 | ix == 10'h093);
  // pins lag reset by two edges, so the hold check waits for them to settle
  reg [1:0] settle_reg;
  always @(posedge clk_i)
    if (rst_i) settle_reg <= 2'h0;
    else if (settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr(logic [9:0] i);
    wr && ix == i;
  endsequence
  sequence s_rd(logic [9:0] i);
    tk && !wb_we_i && ix == i;
  endsequence
  chk_ack_next: assert property (tk |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_input_only: assert property (pin_oe_o[3] == 1'b0)
    else $error("input-only pin driven");
  chk_dir_enable: assert property (s_wr(10'h085) |=> ##1
    pin_oe_o == (~$past(d6, 2) & ~analog_mode_o & 6'h37)) else $error("bad enable");
  chk_latch_out: assert property (s_wr(10'h005) |=> ##1 pin_o == $past(d6, 2))
    else $error("bad pin out");
  chk_latch_hold: assert property (settle_reg == 2'h3 && !$past(lw, 2) |-> $stable(pin_o))
    else $error("latch moved");
  chk_port_read: assert property (s_rd(10'h005) |=>
    wb_dat_o[5:0] == ($past(pin_i) & ~$past(analog_mode_o))) else $error("bad port read");
  chk_dir_read: assert property (s_rd(10'h085) |=> wb_dat_o[7:6] == 2'h0 && wb_dat_o[3])
    else $error("bad dir read");
endmodule // gpe_port_chk
bind gpe_port gpe_port_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o), .analog_mode_o(analog_mode_o));
`default_nettype wire

// *** dv/gpe_port_tb.sv ***
// self-checking bench for the port block
`default_nettype none
module gpe_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h1, sl = 4'h1;
  logic [31:0] wd = 32'h0000_0000, dq, rv;
  logic [5:0] ext = 6'h00, lvl, po, oe, pu, am;
  int err_total = 0, total_checks = 0, n = 0, seed = 36260, lat, dir, opt, ana, st, m, q[$];
  always #25 clk_i = ~clk_i;
  gpe_port dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dq),
    .wb_ack_o(ack), .pin_i(lvl), .pin_o(po), .pin_oe_o(oe), .pullup_en_o(pu),
    .analog_mode_o(am));
  gpe_pins_model far (.drv_i(po), .oe_i(oe), .ext_i(ext), .lvl_o(lvl));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    n++;
    if (n == 20000) begin
      err_total++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input bit w, input int i, input int d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= 12'(i * 4);
    sel <= sl;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rv = dq;
    cyc <= 1'b0;
  endtask
  task automatic rd(input int i, input int e);
    bus(1'b0, i, 0);
    chk(rv, e);
  endtask
  // expected pin levels: driven pins show the latch, the rest the outside
  function automatic int pins();
    int o;
    o = ~dir & ~ana & 8'h37;
    return (o & lat | ~o & ext) & 8'h3F;
  endfunction
  function automatic int prd();
    return lat & 8'hC0 | pins() & ~ana & 8'h3F;
  endfunction
  task automatic outs;
    @(negedge clk_i);
    chk(oe, ~dir & ~ana & 8'h37);
    chk(po, lat & 8'h3F);
    chk(am, ana);
    chk(pu, opt[7] ? 0 : 8'h0B);
  endtask
  task automatic do_rst(input bit p);
    rst_i <= 1'b1;
    por_i <= p;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    dir = 8'h3F;
    opt = 8'hFF;
    st = p ? 8'h18 : st & 8'h1F;
    ana = p ? 8'h17 : ana;
    lat = p ? 8'hC0 : lat | 8'hC0;
    outs;
    rd(8'h85, 8'h3F);
    rd(8'h81, 8'hFF);
    rd(3, st);
    rd(5, prd());
  endtask
  task automatic ser(input int c, input int d);
    lat = lat & 8'h3F | c << 7 | d << 6;
    bus(1'b1, 5, lat);
  endtask
  initial begin
    do_rst(1'b1);
    rd(8'h91, 0);
    bus(1'b1, 8'h89, 0);
    ana = 0;
    for (int k = 0; k < 6; k++) begin
      ext <= 6'($random(seed));
      m = $random(seed);
      dir = m & 8'h3F;
      bus(1'b1, 8'h85, m);
      lat = $random(seed) & 8'h3F | 8'hC0;
      bus(1'b1, 5, lat);
      opt = $random(seed) & 8'hFF;
      bus(1'b1, 8'h81, opt);
      outs;
      rd(5, prd());
      rd(8'h85, dir & 8'h37 | 8'h08);
      m = 1 << k;
      lat = k[0] ? prd() & ~m : prd() | m;
      bus(1'b1, 8'h92 + k[0], m);
      outs;
    end
    bus(1'b1, 3, 8'h27);
    st = 8'h3F;
    rd(3, st);
    bus(1'b1, 8'h40, 8'h55);
    rd(8'h40, 0);
    sl = 4'h0;
    bus(1'b1, 8'h81, 0);
    sl = 4'h1;
    rd(8'h81, opt);
    do_rst(1'b0);
    ser(1, 1);
    ser(1, 0);
    for (int b = 0; b < 17; b++) begin
      m = $random(seed) & 8'hFF;
      q.push_back(m);
      for (int i = 7; i >= 0; i--) begin
        ser(0, lat >> 6 & 1);
        ser(0, m >> i & 1);
        ser(1, m >> i & 1);
      end
    end
    ser(0, 0);
    ser(1, 0);
    ser(1, 1);
    rd(8'h91, 16);
    bus(1'b0, 8'h90, 0);
    chk(rv & 8'h13, 8'h11);
    for (int b = 0; b < 16; b++)
      rd(8'hA0 + b, q[b]);
    stop_test;
  end
endmodule // gpe_port_tb
`default_nettype wire

// *** verilog/gpe_defs.vh ***
// constants for the eight-bit port with internal two-wire memory lines
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Every pin works both ways except the input-only pin, which never drives.
// - Port reads return live pin levels sampled at read time, never latched.
// - Output latches hold their value until software writes them again.
// - Direction bit 0 drives the pin from its latch; 1 makes it input.
// - Bit 6 is internal serial data, bit 7 internal serial clock; no pins.
// - After power-on the four analog-capable pins are analog and read 0.
// - Every reset sets the six direction bits to all ones.
// - Power-on: port bits 7,6 one, rest unknown (here cleared to 0); other resets keep lower bits.
// - Without the internal memory the serial bits are unimplemented.
// - Port read gives pin levels; port write loads the output latches.
// - Bit set/clear read the pins, modify, and write all latches back.
// - Serial data changes only while clock low, except start and stop.
// - Bus idle means both lines high; transfers start only from idle.
// - Data falling while clock high is a start; commands begin with one.
// - Data rising while clock high is a stop; operations end with one.
// - One bit per clock pulse, valid if data stable while clock high.
// - The memory holds sixteen bytes; that bounds bytes per transfer.
// - Direction reads 1 at the input-only pin and 0 at both serial bits.
// ----------------------------------------------------------------------------
`ifndef GPE_DEFS_VH
`define GPE_DEFS_VH

// register indices; byte address is four times the index
`define GPE_IDX_STATUS 10'h003
`define GPE_IDX_PORT 10'h005
`define GPE_IDX_OPTION 10'h081
`define GPE_IDX_DIR 10'h085
`define GPE_IDX_ANALOG 10'h089
`define GPE_IDX_MSTAT 10'h090
`define GPE_IDX_MCOUNT 10'h091
`define GPE_IDX_BSET 10'h092
`define GPE_IDX_BCLR 10'h093
`define GPE_IDX_MEM_BASE 6'h0A

// reset values
`define GPE_STATUS_POR 8'h18
`define GPE_STATUS_KEEP 8'h1F
`define GPE_OPTION_RST 8'hFF
`define GPE_DIR_RST 6'h3F
`define GPE_PORT_SER_RST 2'h3
`define GPE_PORT_LOW_POR 6'h00
`define GPE_ANALOG_POR 6'h17

// field positions
`define GPE_INPUT_ONLY_BIT 3
`define GPE_SER_DATA_BIT 6
`define GPE_SER_CLK_BIT 7
`define GPE_PULLUP_DIS_BIT 7
`define GPE_PULLUP_PINS 6'h0B
`define GPE_MST_IDLE 0
`define GPE_MST_ACTIVE 1
`define GPE_MST_START 2
`define GPE_MST_STOP 3
`define GPE_MST_OVF 4

// memory monitor
`define GPE_MEM_BYTES 16
`define GPE_BITS_PER_BYTE 4'h8
`define GPE_CNT_W 5

`endif

// *** verilog/gpe_port.v ***
// eight-bit port with wishbone registers and internal two-wire memory monitor
`include "gpe_defs.vh"
`default_nettype none

module gpe_port #(
  parameter HAS_MEMORY = 1,
  parameter MEM_BYTES = `GPE_MEM_BYTES
) (
  input wire clk_i,
  input wire rst_i,
  input wire por_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [5:0] pin_i,
  output reg [5:0] pin_o,
  output reg [5:0] pin_oe_o,
  output reg [5:0] pullup_en_o,
  output reg [5:0] analog_mode_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg [7:0] status_reg;
  reg [7:0] option_reg;
  reg [5:0] dir_reg;
  reg [7:0] latch_reg;
  reg [5:0] analog_reg;
  reg ser_clk_prev_reg;
  reg ser_data_prev_reg;
  reg active_reg;
  reg clk_high_data_reg;
  // the clock fall that closes a start carries no data, so a bit needs a rise first
  reg rise_seen_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [`GPE_CNT_W-1:0] byte_cnt_reg;
  reg start_seen_reg;
  reg stop_seen_reg;
  reg ovf_reg;
  reg [7:0] mem [0:MEM_BYTES-1];

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [9:0] idx = wb_adr_i[11:2];
  wire power_on = rst_i & por_i;
  wire mem_on = (HAS_MEMORY != 0);

  // --------------------------------------------------------------------------
  // pin view and direction view
  // --------------------------------------------------------------------------
  // nothing on the internal lines pulls low here, so with the memory present the line follows its latch; without it the line is 0
  wire ser_data_line = latch_reg[`GPE_SER_DATA_BIT] & mem_on;
  wire ser_clk_line = latch_reg[`GPE_SER_CLK_BIT] & mem_on;

  // live pins, analog pins forced to zero, serial bits from the internal lines
  wire [7:0] pin_view = {ser_clk_line, ser_data_line, pin_i & ~analog_reg};

  function [7:0] dir_view;
    input [5:0] d;
    input has_mem;
    reg [5:0] t;
    begin
      t = d;
      t[`GPE_INPUT_ONLY_BIT] = 1'b1;
      dir_view = {2'b00, t};
      if (!has_mem) begin
        dir_view = {2'b00, t};
      end
    end
  endfunction

  function is_mem_idx;
    input [9:0] i;
    begin
      is_mem_idx = (i[9:4] == `GPE_IDX_MEM_BASE);
    end
  endfunction

  // --------------------------------------------------------------------------
  // bus slave: answers one cycle after the request, unmapped reads zero
  // --------------------------------------------------------------------------
  reg [31:0] rd_data;
  always @* begin
    rd_data = 32'h0000_0000;
    case (idx)
      `GPE_IDX_STATUS: rd_data = {24'h00_0000, status_reg};
      `GPE_IDX_PORT: rd_data = {24'h00_0000, pin_view};
      `GPE_IDX_OPTION: rd_data = {24'h00_0000, option_reg};
      `GPE_IDX_DIR: rd_data = {24'h00_0000, dir_view(dir_reg, mem_on)};
      `GPE_IDX_ANALOG: rd_data = {26'h000_0000, analog_reg};
      `GPE_IDX_MSTAT: rd_data = {27'h000_0000, ovf_reg, stop_seen_reg, start_seen_reg,
                                 active_reg, ~active_reg & ser_clk_line & ser_data_line};
      `GPE_IDX_MCOUNT: rd_data = {27'h000_0000, byte_cnt_reg};
      default: begin
        if (is_mem_idx(idx) && mem_on) begin
          rd_data = {24'h00_0000, mem[idx[3:0]]};
        end
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // --------------------------------------------------------------------------
  // cpu status, option, direction, analog select
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (power_on) begin
      status_reg <= `GPE_STATUS_POR;
    end else if (rst_i) begin
      status_reg <= status_reg & `GPE_STATUS_KEEP;
    end else if (wr && idx == `GPE_IDX_STATUS) begin
      // timeout and power-down flags are not software writable
      status_reg <= (wb_dat_i[7:0] & ~`GPE_STATUS_POR) | (status_reg & `GPE_STATUS_POR);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      option_reg <= `GPE_OPTION_RST;
      dir_reg <= `GPE_DIR_RST;
    end else begin
      if (wr && idx == `GPE_IDX_OPTION) begin
        option_reg <= wb_dat_i[7:0];
      end
      if (wr && idx == `GPE_IDX_DIR) begin
        dir_reg <= wb_dat_i[5:0];
      end
    end
  end

  // analog mode survives non-power-on resets
  always @(posedge clk_i) begin
    if (power_on) begin
      analog_reg <= `GPE_ANALOG_POR;
    end else if (wr && idx == `GPE_IDX_ANALOG) begin
      analog_reg <= wb_dat_i[5:0] & `GPE_ANALOG_POR;
    end
  end

  // --------------------------------------------------------------------------
  // output latches
  // --------------------------------------------------------------------------
  // set and clear act on the pin levels, so input pins' latches take the pins
  wire [7:0] bset_val = pin_view | wb_dat_i[7:0];
  wire [7:0] bclr_val = pin_view & ~wb_dat_i[7:0];
  wire [7:0] ser_mask = mem_on ? 8'hFF : 8'h3F;

  always @(posedge clk_i) begin
    if (power_on) begin
      latch_reg <= {`GPE_PORT_SER_RST, `GPE_PORT_LOW_POR};
    end else if (rst_i) begin
      latch_reg <= {`GPE_PORT_SER_RST, latch_reg[5:0]};
    end else if (wr && idx == `GPE_IDX_PORT) begin
      latch_reg <= wb_dat_i[7:0] & ser_mask;
    end else if (wr && idx == `GPE_IDX_BSET) begin
      latch_reg <= bset_val & ser_mask;
    end else if (wr && idx == `GPE_IDX_BCLR) begin
      latch_reg <= bclr_val & ser_mask;
    end
    // otherwise the latch holds
  end

  // --------------------------------------------------------------------------
  // pin drivers, registered so every output comes from a flip-flop
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_pin
      always @(posedge clk_i) begin
        if (rst_i) begin
          pin_o[g] <= 1'b0;
          pin_oe_o[g] <= 1'b0;
        end else begin
          pin_o[g] <= latch_reg[g];
          if (g == `GPE_INPUT_ONLY_BIT) begin
            pin_oe_o[g] <= 1'b0;
          end else begin
            pin_oe_o[g] <= ~dir_reg[g] & ~analog_reg[g];
          end
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      pullup_en_o <= 6'h00;
      analog_mode_o <= `GPE_ANALOG_POR;
    end else begin
      pullup_en_o <= option_reg[`GPE_PULLUP_DIS_BIT] ? 6'h00 : `GPE_PULLUP_PINS;
      analog_mode_o <= analog_reg;
    end
  end

  // --------------------------------------------------------------------------
  // internal two-wire memory: bus conditions and byte capture
  // --------------------------------------------------------------------------
  wire clk_high = ser_clk_prev_reg & ser_clk_line;
  wire start_ev = mem_on & clk_high & ser_data_prev_reg & ~ser_data_line;
  wire stop_ev = mem_on & clk_high & ~ser_data_prev_reg & ser_data_line;
  wire clk_rise = mem_on & ~ser_clk_prev_reg & ser_clk_line;
  wire clk_fall = mem_on & ser_clk_prev_reg & ~ser_clk_line;
  // a bit counts only if data held steady for the whole high phase
  wire bit_ev = active_reg & rise_seen_reg & clk_fall & ~start_ev;
  wire byte_done = bit_ev & (bit_cnt_reg == `GPE_BITS_PER_BYTE - 4'h1);
  wire room = (byte_cnt_reg < MEM_BYTES);
  wire sticky_wr = wr && idx == `GPE_IDX_MSTAT;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ser_clk_prev_reg <= 1'b1;
      ser_data_prev_reg <= 1'b1;
      active_reg <= 1'b0;
      clk_high_data_reg <= 1'b1;
      rise_seen_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_cnt_reg <= {`GPE_CNT_W{1'b0}};
    end else begin
      ser_clk_prev_reg <= ser_clk_line;
      ser_data_prev_reg <= ser_data_line;
      if (clk_rise) begin
        clk_high_data_reg <= ser_data_line;
        rise_seen_reg <= 1'b1;
      end
      if (start_ev) begin
        active_reg <= 1'b1;
        rise_seen_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        byte_cnt_reg <= {`GPE_CNT_W{1'b0}};
      end else if (stop_ev) begin
        active_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
      end else if (bit_ev) begin
        shift_reg <= {shift_reg[6:0], clk_high_data_reg};
        if (byte_done) begin
          bit_cnt_reg <= 4'h0;
          if (room) begin
            byte_cnt_reg <= byte_cnt_reg + {{(`GPE_CNT_W-1){1'b0}}, 1'b1};
          end
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end
    end
  end

  // bytes beyond capacity are dropped and flagged
  always @(posedge clk_i) begin
    if (byte_done && room) begin
      mem[byte_cnt_reg[3:0]] <= {shift_reg[6:0], clk_high_data_reg};
    end
  end

  // sticky flags: an event in the clearing cycle still sets the flag
  always @(posedge clk_i) begin
    if (rst_i) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      start_seen_reg <= (start_seen_reg & ~(sticky_wr & wb_dat_i[`GPE_MST_START])) | start_ev;
      stop_seen_reg <= (stop_seen_reg & ~(sticky_wr & wb_dat_i[`GPE_MST_STOP])) | stop_ev;
      ovf_reg <= (ovf_reg & ~(sticky_wr & wb_dat_i[`GPE_MST_OVF])) |
                 (byte_done & ~room);
    end
  end

endmodule // gpe_port

`default_nettype wire
